// ==== verilog/ats_pkg.sv ====
// shared constants and types of the transfer switch supervisor
// assumes one 40 MHz clock; all long timing is counted in quarter-second ticks
package ats_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_HZ        = 40_000_000;
    localparam int unsigned TICK_MS         = 250;
    localparam int unsigned TICK_CYCLES     = CLOCK_HZ / 1000 * TICK_MS;

    // ------------------------------------------------------------
    // delays, in milliseconds, and their tick counts
    // ------------------------------------------------------------
    localparam int unsigned ACQUIRE_MS      = 78_000;
    localparam int unsigned RETRANSFER_MS   = 360_000;
    localparam int unsigned COOLDOWN_MS     = 300_000;
    localparam int unsigned ATTEMPT_MS      = 1_000;
    localparam int unsigned FAULT_HOLD_MS   = 3_000;
    localparam int unsigned CTRL_HOLD_MS    = 6_000;
    localparam int unsigned ACK_MS          = 1_000;
    localparam int unsigned ACQUIRE_TICKS   = ACQUIRE_MS / TICK_MS;
    localparam int unsigned RETRANS_TICKS   = RETRANSFER_MS / TICK_MS;
    localparam int unsigned COOLDOWN_TICKS  = COOLDOWN_MS / TICK_MS;
    localparam int unsigned ATTEMPT_TICKS   = ATTEMPT_MS / TICK_MS;
    localparam int unsigned FAULT_HOLD_TICKS = FAULT_HOLD_MS / TICK_MS;
    localparam int unsigned CTRL_HOLD_TICKS = CTRL_HOLD_MS / TICK_MS;
    localparam int unsigned ACK_TICKS       = ACK_MS / TICK_MS;
    localparam int unsigned TIMER_W         = 12;
    localparam int unsigned HOLD_W          = 5;

    // ------------------------------------------------------------
    // flash frames, in ticks
    // ------------------------------------------------------------
    localparam logic [5:0]  FRAME_TICKS     = 6'h28;
    localparam logic [5:0]  SLOW_PERIOD     = 6'h08;
    localparam logic [5:0]  SLOW_ON         = 6'h04;
    localparam logic [5:0]  EXER_PERIOD     = 6'h0a;
    localparam logic [5:0]  EXER_ON         = 6'h02;

    // ------------------------------------------------------------
    // sensing thresholds, percent of nominal; transfer attempt count
    // ------------------------------------------------------------
    localparam logic [7:0]  UV_DROPOUT      = 8'h50;
    localparam logic [7:0]  UV_PICKUP       = 8'h55;
    localparam logic [7:0]  UF_DROPOUT      = 8'h5a;
    localparam logic [7:0]  UF_PICKUP       = 8'h60;
    localparam logic [1:0]  XFER_TRIES      = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic util_avail;
        logic util_pos;
        logic gen_avail;
        logic gen_pos;
    } led_t;

    typedef struct packed {
        logic test_loaded;
        logic test_unloaded;
        logic exer_loaded;
        logic exer_unloaded;
    } run_mode_t;

    typedef struct packed {
        logic [7:0] util_volt;
        logic [7:0] gen_volt;
        logic [7:0] gen_freq;
    } sense_t;

    typedef enum logic [5:0] {
        S_IDLE   = 6'h01,
        S_START  = 6'h02,
        S_XFER_E = 6'h04,
        S_EMER   = 6'h08,
        S_XFER_N = 6'h10,
        S_COOL   = 6'h20
    } state_t;

endpackage

// ==== verilog/tick_timer.sv ====
// tick-driven elapsed timer, cleared whenever run drops
// assumes tick is a one-cycle pulse from the same clock
module tick_timer #(
    parameter int unsigned W = 12
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // control
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    // status
    output logic              done
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    wire          reached = (count_q >= limit);

    assign count_d = !run ? '0 : (tick && !reached) ? count_q + 1'b1 : count_q;
    assign done    = run && reached;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else
            count_q <= count_d;
    end

endmodule

// ==== verilog/ats_supervisor.sv ====
// transfer switch supervisor: sensing, transfer sequencing, faults, leds
// assumes pin inputs are asynchronous and sense words come from clocked logic
//
// Function
// - steady leds show availability and position
// - loaded test flashes gen leds 1s/1s
// - unloaded test flashes gen available 1s/1s
// - loaded exercise flashes gen leds 0.5s/2s
// - unloaded exercise flashes gen available 0.5s/2s
// - acquire fault flashes gen available twice/second
// - transfer fault flashes a position led fast
// - aux fault alternates both position leds fast
// - 78s without generator raises acquire fault
// - commanded transfer not confirmed means failure
// - three attempts before transfer failure fault
// - transfer or aux fault in normal position: cooldown then stop
// - uncommanded position change raises aux fault
// - ambiguous aux switches raise aux fault
// - 3s two-button hold clears faults, flashes
// - warnings clear on availability change, transfer
// - common fault follows acquire, transfer and aux faults
// - 6s hold restores power-up state, clears exercise
// - both buttons silence horn with accessory board
// - transfer below 80%, retransfer after 6min
// - generator-only underfrequency at 90%/96%
// - own exercise overrides generator controller exercise
module ats_supervisor #(
    parameter int unsigned TICK_CYCLES = ats_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // operator panel pins
    input  wire logic              test_button,
    input  wire logic              exercise_button,
    input  wire logic              accessory_fitted,
    // contactor position pins
    input  wire logic              aux_normal_closed,
    input  wire logic              aux_emer_closed,
    // source sensing and run requests, same clock
    input  ats_pkg::sense_t        sense,
    input  ats_pkg::run_mode_t     run_mode,
    input  wire logic              gen_exercise_req,
    // outputs
    output ats_pkg::led_t          leds,
    output logic                   engine_start,
    output logic                   xfer_to_emer,
    output logic                   xfer_to_norm,
    output logic                   common_fault,
    output logic                   alarm_horn,
    output logic                   gen_exercise_allow,
    output logic                   exercise_clear
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] meta_q;
    logic [4:0] pin_q;
    logic [2:0] settle_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q   <= '0;
            pin_q    <= '0;
            settle_q <= '0;
        end
        else
        begin
            meta_q <= {accessory_fitted, aux_emer_closed, aux_normal_closed, exercise_button, test_button};
            pin_q    <= meta_q;
            settle_q <= {settle_q[1:0], 1'b1};
        end
    end

    wire both_pressed = pin_q[0] && pin_q[1];
    wire aux_n        = pin_q[2];
    wire aux_e        = pin_q[3];
    wire acc_fitted   = pin_q[4];
    wire pos_norm     = aux_n && !aux_e;
    wire pos_emer     = aux_e && !aux_n;
    wire pos_bad      = aux_n == aux_e;

    // ------------------------------------------------------------
    // tick and flash phase
    // ------------------------------------------------------------
    logic [31:0] pre_q;
    logic [5:0]  phase_q;
    wire         tick = (pre_q == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q   <= '0;
            phase_q <= '0;
        end
        else
        begin
            pre_q <= tick ? '0 : pre_q + 32'h1;
            if (tick)
                phase_q <= (phase_q == ats_pkg::FRAME_TICKS - 6'h01) ? '0 : phase_q + 6'h01;
        end
    end

    // the frame is a common multiple of both periods, so wrap is seamless
    wire flash_slow = (phase_q % ats_pkg::SLOW_PERIOD) < ats_pkg::SLOW_ON;
    wire flash_exer = (phase_q % ats_pkg::EXER_PERIOD) < ats_pkg::EXER_ON;
    wire flash_fast = !phase_q[0];

    // ------------------------------------------------------------
    // source sensing with hysteresis
    // ------------------------------------------------------------
    logic util_low_q;
    logic gen_v_ok_q;
    logic gen_f_ok_q;
    logic gen_ok_prev_q;
    logic util_low_prev_q;

    wire  gen_avail    = gen_v_ok_q && gen_f_ok_q;
    wire  avail_change = (gen_avail != gen_ok_prev_q) || (util_low_q != util_low_prev_q);

    // ------------------------------------------------------------
    // two-button hold
    // ------------------------------------------------------------
    logic [ats_pkg::HOLD_W-1:0] hold_q;
    logic                       both_prev_q;
    wire                        hold_step  = tick && both_pressed && hold_q != ats_pkg::HOLD_W'(ats_pkg::CTRL_HOLD_TICKS);
    wire                        fault_rst  = hold_step && hold_q == ats_pkg::HOLD_W'(ats_pkg::FAULT_HOLD_TICKS - 1);
    wire                        soft_rst   = hold_step && hold_q == ats_pkg::HOLD_W'(ats_pkg::CTRL_HOLD_TICKS - 1);
    wire                        press_edge = both_pressed && !both_prev_q;

    // ------------------------------------------------------------
    // sequencing state
    // ------------------------------------------------------------
    ats_pkg::state_t state_q;
    ats_pkg::state_t state_d;
    logic [1:0]      tries_q;
    logic            outage_q;
    logic            acq_q;
    logic            ftt_q;
    logic            aux_q;
    logic            silence_q;
    logic            ack_q;
    logic            pos_prev_n_q;
    logic            pos_prev_e_q;

    wire loaded     = run_mode.test_loaded || run_mode.exer_loaded;
    wire need_emer  = util_low_q || loaded;
    wire run_req    = need_emer || run_mode.test_unloaded || run_mode.exer_unloaded;
    wire lockout    = ftt_q || aux_q;
    wire in_xfer    = state_q == ats_pkg::S_XFER_E || state_q == ats_pkg::S_XFER_N;
    wire pos_moved  = !pos_bad && (aux_n != pos_prev_n_q || aux_e != pos_prev_e_q);
    // reset zeros in the sync and last-position flops would read as a false aux fault
    wire aux_event  = settle_q[2] && (pos_bad || (pos_moved && !in_xfer));
    wire any_fault  = acq_q || ftt_q || aux_q;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    logic acq_done;
    logic att_done;
    logic ret_done;
    logic cool_done;
    logic ack_done;

    tick_timer #(.W(ats_pkg::TIMER_W)) u_acquire (
        .clock (clock), .rst_n (rst_n), .tick (tick),
        .run   (state_q == ats_pkg::S_START && !gen_avail),
        .limit (ats_pkg::TIMER_W'(ats_pkg::ACQUIRE_TICKS)),
        .done  (acq_done)
    );

    // attempt timer drops for one cycle after expiry to start the next try
    logic att_gap_q;
    tick_timer #(.W(ats_pkg::TIMER_W)) u_attempt (
        .clock (clock), .rst_n (rst_n), .tick (tick),
        .run   (in_xfer && !att_gap_q),
        .limit (ats_pkg::TIMER_W'(ats_pkg::ATTEMPT_TICKS)),
        .done  (att_done)
    );

    tick_timer #(.W(ats_pkg::TIMER_W)) u_retransfer (
        .clock (clock), .rst_n (rst_n), .tick (tick),
        .run   (state_q == ats_pkg::S_EMER && !util_low_q),
        .limit (ats_pkg::TIMER_W'(ats_pkg::RETRANS_TICKS)),
        .done  (ret_done)
    );

    tick_timer #(.W(ats_pkg::TIMER_W)) u_cooldown (
        .clock (clock), .rst_n (rst_n), .tick (tick),
        .run   (state_q == ats_pkg::S_COOL),
        .limit (ats_pkg::TIMER_W'(ats_pkg::COOLDOWN_TICKS)),
        .done  (cool_done)
    );

    tick_timer #(.W(ats_pkg::TIMER_W)) u_ack (
        .clock (clock), .rst_n (rst_n), .tick (tick),
        .run   (ack_q),
        .limit (ats_pkg::TIMER_W'(ats_pkg::ACK_TICKS)),
        .done  (ack_done)
    );

    wire last_try  = att_done && tries_q == ats_pkg::XFER_TRIES - 2'h1;
    wire ftt_event = last_try && in_xfer;
    wire leave_emer = !ftt_q && (!gen_avail || (!need_emer && (ret_done || !outage_q)));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ats_pkg::S_IDLE:
                if (run_req && !lockout)
                    state_d = ats_pkg::S_START;
            ats_pkg::S_START:
                if (aux_q && pos_norm)
                    state_d = ats_pkg::S_COOL;
                else if (!run_req)
                    state_d = ats_pkg::S_COOL;
                else if (gen_avail && need_emer && !lockout)
                    state_d = ats_pkg::S_XFER_E;
            ats_pkg::S_XFER_E:
                if (pos_emer)
                    state_d = ats_pkg::S_EMER;
                else if (ftt_event)
                    state_d = ats_pkg::S_COOL;
            ats_pkg::S_EMER:
                if (leave_emer)
                    state_d = ats_pkg::S_XFER_N;
            ats_pkg::S_XFER_N:
                if (pos_norm)
                    state_d = run_req ? ats_pkg::S_START : ats_pkg::S_COOL;
                else if (ftt_event)
                    state_d = ats_pkg::S_EMER;
            ats_pkg::S_COOL:
                if (cool_done)
                    state_d = ats_pkg::S_IDLE;
                else if (run_req && !lockout)
                    state_d = ats_pkg::S_START;
            default:
                state_d = ats_pkg::S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing registers; a long hold acts as a power-up restart
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q  <= ats_pkg::S_IDLE;
            tries_q  <= '0;
            outage_q <= 1'b0;
            att_gap_q <= 1'b0;
        end
        else if (soft_rst)
        begin
            state_q  <= ats_pkg::S_IDLE;
            tries_q  <= '0;
            outage_q <= 1'b0;
            att_gap_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            att_gap_q <= att_done;
            if (!in_xfer || state_d != state_q)
                tries_q <= '0;
            else if (att_done)
                tries_q <= tries_q + 2'h1;
            if (state_q == ats_pkg::S_IDLE)
                outage_q <= util_low_q;
        end
    end

    // ------------------------------------------------------------
    // sensing, fault and indication registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            util_low_q      <= 1'b0;
            gen_v_ok_q      <= 1'b0;
            gen_f_ok_q      <= 1'b0;
            gen_ok_prev_q   <= 1'b0;
            util_low_prev_q <= 1'b0;
            acq_q           <= 1'b0;
            ftt_q           <= 1'b0;
            aux_q           <= 1'b0;
            silence_q       <= 1'b0;
            ack_q           <= 1'b0;
            hold_q          <= '0;
            both_prev_q     <= 1'b0;
            pos_prev_n_q    <= 1'b0;
            pos_prev_e_q    <= 1'b0;
        end
        else
        begin
            if (sense.util_volt < ats_pkg::UV_DROPOUT)
                util_low_q <= 1'b1;
            else if (sense.util_volt >= ats_pkg::UV_PICKUP)
                util_low_q <= 1'b0;
            if (sense.gen_volt < ats_pkg::UV_DROPOUT)
                gen_v_ok_q <= 1'b0;
            else if (sense.gen_volt >= ats_pkg::UV_PICKUP)
                gen_v_ok_q <= 1'b1;
            // frequency is watched on the generator only
            if (sense.gen_freq < ats_pkg::UF_DROPOUT)
                gen_f_ok_q <= 1'b0;
            else if (sense.gen_freq >= ats_pkg::UF_PICKUP)
                gen_f_ok_q <= 1'b1;
            gen_ok_prev_q   <= gen_avail;
            util_low_prev_q <= util_low_q;
            pos_prev_n_q    <= aux_n;
            pos_prev_e_q    <= aux_e;
            both_prev_q     <= both_pressed;
            hold_q <= !both_pressed ? '0 : hold_step ? hold_q + 1'b1 : hold_q;

            // each fault: setting event beats any clear in the same cycle
            if (acq_done)
                acq_q <= 1'b1;
            else if (gen_avail || fault_rst || soft_rst)
                acq_q <= 1'b0;
            if (ftt_event)
                ftt_q <= 1'b1;
            else if (avail_change || state_d != state_q && (state_d == ats_pkg::S_XFER_E
                     || state_d == ats_pkg::S_XFER_N) || fault_rst || soft_rst)
                ftt_q <= 1'b0;
            if (aux_event)
                aux_q <= 1'b1;
            else if (fault_rst || soft_rst)
                aux_q <= 1'b0;

            // silence lasts until a fresh fault appears
            if (press_edge && acc_fitted)
                silence_q <= 1'b1;
            else if ((acq_done && !acq_q) || (ftt_event && !ftt_q) || (aux_event && !aux_q))
                silence_q <= 1'b0;

            if (fault_rst || soft_rst)
                ack_q <= 1'b1;
            else if (ack_done)
                ack_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // led selection, acknowledge flash first, then faults
    // ------------------------------------------------------------
    ats_pkg::led_t led_d;
    wire exer_on = run_mode.exer_loaded || run_mode.exer_unloaded;
    wire test_on = run_mode.test_loaded || run_mode.test_unloaded;

    assign led_d.util_avail = ack_q ? flash_fast : !util_low_q;
    assign led_d.util_pos   = ack_q ? flash_fast
                            : aux_q ? !flash_fast
                            : (ftt_q && pos_norm) ? flash_fast
                            : pos_norm;
    assign led_d.gen_avail  = ack_q ? flash_fast
                            : acq_q ? flash_fast
                            : test_on ? flash_slow
                            : exer_on ? flash_exer
                            : gen_avail;
    assign led_d.gen_pos    = ack_q ? flash_fast
                            : aux_q ? flash_fast
                            : (ftt_q && !pos_norm) ? flash_fast
                            : run_mode.test_loaded ? flash_slow
                            : run_mode.exer_loaded ? flash_exer
                            : pos_emer;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            leds               <= '0;
            engine_start       <= 1'b0;
            xfer_to_emer       <= 1'b0;
            xfer_to_norm       <= 1'b0;
            common_fault       <= 1'b0;
            alarm_horn         <= 1'b0;
            gen_exercise_allow <= 1'b0;
            exercise_clear     <= 1'b0;
        end
        else
        begin
            leds               <= led_d;
            engine_start       <= state_d != ats_pkg::S_IDLE;
            xfer_to_emer       <= state_d == ats_pkg::S_XFER_E && !att_done;
            xfer_to_norm       <= state_d == ats_pkg::S_XFER_N && !att_done;
            common_fault       <= any_fault;
            alarm_horn         <= acc_fitted && any_fault && !silence_q;
            gen_exercise_allow <= gen_exercise_req && !exer_on;
            exercise_clear     <= soft_rst;
        end
    end

endmodule

// ==== test/ats_far_side.sv ====
// generator and transfer contactor seen from the supervisor pins
// assumes the bench orders the faults; changes land on the falling edge
module ats_far_side (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // commands from the supervisor
    input  wire logic       engine_start,
    input  wire logic       xfer_to_emer,
    input  wire logic       xfer_to_norm,
    // faults ordered by the bench
    input  wire logic       gen_dead,
    input  wire logic       stuck,
    input  wire logic       aux_bad,
    // pins toward the supervisor
    output logic            aux_normal_closed,
    output logic            aux_emer_closed,
    output logic [7:0]      gen_volt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic emer_q = 1'b0;
    logic run_q  = 1'b0;
    always @(negedge clock)
    begin
        run_q <= engine_start & !gen_dead;
        if (!rst_n) emer_q <= 1'b0;
        else if (!stuck && xfer_to_emer) emer_q <= 1'b1;
        else if (!stuck && xfer_to_norm) emer_q <= 1'b0;
    end
    assign gen_volt          = run_q ? 8'h64 : 8'h00;
    // both closed when broken, so the position reads ambiguous
    assign aux_emer_closed   = aux_bad | emer_q;
    assign aux_normal_closed = aux_bad | !emer_q;
endmodule

// ==== test/ats_supervisor_assertions.sv ====
// checker on the supervisor pins
// assumes sense and run requests come from the supervisor clock
module ats_supervisor_assertions #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic clock, rst_n, test_button, exercise_button, gen_exercise_req,
    input ats_pkg::sense_t sense,
    input ats_pkg::run_mode_t run_mode,
    input ats_pkg::led_t leds,
    input wire logic engine_start, xfer_to_emer, xfer_to_norm, common_fault, alarm_horn,
    input wire logic gen_exercise_allow, exercise_clear
);
    logic        own_exer;
    logic [15:0] calm_q;
    assign own_exer = run_mode.exer_loaded | run_mode.exer_unloaded;
    // util led judged only once any acknowledge flash is long over
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n) calm_q <= 16'h0;
        else if (sense.util_volt < 8'h55 || test_button || exercise_button) calm_q <= 16'h0;
        else if (calm_q != 16'hffff) calm_q <= calm_q + 16'h1;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_clear_pulse: assert property (exercise_clear |=> !exercise_clear) else $error("clear pulse long");
    a_xfer_excl: assert property (!(xfer_to_emer && xfer_to_norm)) else $error("two commands");
    a_xfer_engine: assert property (xfer_to_emer |-> engine_start) else $error("transfer, no engine");
    a_start_outage:
        assert property ((sense.util_volt < 8'h50 && !common_fault) [*5] |-> engine_start) else $error("no start");
    a_exer_own: assert property (own_exer [*2] |-> !gen_exercise_allow) else $error("own exercise lost");
    a_exer_pass:
        assert property ((gen_exercise_req && !own_exer) [*3] |-> gen_exercise_allow) else $error("req blocked");
    a_horn_fault: assert property (alarm_horn |-> common_fault || $past(common_fault)) else $error("horn");
    a_util_steady: assert property (calm_q >= 20 * TICK_CYCLES |-> leds.util_avail) else $error("util led");
    cover property ($rose(engine_start));
    cover property ($rose(common_fault));
    cover property (exercise_clear);
endmodule
bind ats_supervisor ats_supervisor_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (.clock, .rst_n,
    .test_button, .exercise_button, .gen_exercise_req, .sense, .run_mode, .leds, .engine_start, .xfer_to_emer,
    .xfer_to_norm, .common_fault, .alarm_horn, .gen_exercise_allow, .exercise_clear);

// ==== test/test_ats_supervisor.sv ====
// self-checking bench for the transfer switch supervisor
// assumes a quarter-second tick shortened to four clocks
module test_ats_supervisor;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int T = 4;
    logic clock = 1'b0, rst_n = 1'b0, test_button = 1'b0, exercise_button = 1'b0, accessory_fitted = 1'b1;
    logic gen_exercise_req = 1'b0, gen_dead = 1'b0, stuck = 1'b0, aux_bad = 1'b0;
    logic aux_normal_closed, aux_emer_closed, engine_start, xfer_to_emer, xfer_to_norm;
    logic common_fault, alarm_horn, gen_exercise_allow, exercise_clear;
    logic [7:0] util_volt = 8'h64, gen_volt;
    ats_pkg::sense_t sense;
    ats_pkg::run_mode_t run_mode = 4'h0;
    ats_pkg::led_t leds;
    int n_errors = 0, n_checks = 0, ha, hp, ch;
    assign sense = {util_volt, gen_volt, gen_volt};
    ats_supervisor #(.TICK_CYCLES(T)) ats_supervisor_inst (.clock, .rst_n, .test_button, .exercise_button,
        .accessory_fitted, .aux_normal_closed, .aux_emer_closed, .sense, .run_mode, .gen_exercise_req, .leds,
        .engine_start, .xfer_to_emer, .xfer_to_norm, .common_fault, .alarm_horn, .gen_exercise_allow,
        .exercise_clear);
    ats_far_side ats_far_side_inst (.clock, .rst_n, .engine_start, .xfer_to_emer, .xfer_to_norm, .gen_dead,
        .stuck, .aux_bad, .aux_normal_closed, .aux_emer_closed, .gen_volt);
    initial forever #12.5 clock = ~clock;
    task automatic cyc(input int n); repeat (n) @(negedge clock); endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end
    endtask
    task automatic do_reset;
        rst_n = 1'b0; util_volt = 8'h64; run_mode = 4'h0; gen_dead = 1'b0; stuck = 1'b0; aux_bad = 1'b0;
        cyc(16); rst_n = 1'b1; cyc(8);
    endtask
    task automatic press(input logic v); test_button = v; exercise_button = v; endtask
    // counts lit cycles of both generator leds and changes of the available one
    task automatic scan(input int n);
        logic p;
        ha = 0; hp = 0; ch = 0; p = leds.gen_avail;
        repeat (n) begin cyc(1); ha += leds.gen_avail; hp += leds.gen_pos; ch += (leds.gen_avail != p);
            p = leds.gen_avail; end
    endtask
    task automatic t_outage;
        chk(leds, 4'hc);
        util_volt = 8'h40; cyc(8); chk(engine_start, 1'b1);
        cyc(40); chk({leds.util_pos, leds.gen_pos}, 2'h1);
        util_volt = 8'h64; cyc(1400 * T); chk(leds.gen_pos, 1'b1);
        cyc(60 * T); chk(leds.util_pos, 1'b1);
    endtask
    task automatic t_acquire;
        gen_dead = 1'b1; util_volt = 8'h40; cyc(300 * T); chk(common_fault, 1'b0);
        cyc(20 * T); chk(common_fault, 1'b1);
        scan(8 * T); chk(ch, 8);
        gen_dead = 1'b0; cyc(20 * T); scan(8 * T); chk(ha, 8 * T);
        util_volt = 8'h64; cyc(8); press(1'b1); cyc(13 * T); scan(2 * T); chk(ch, 2);
        press(1'b0); cyc(8); chk(common_fault, 1'b0);
    endtask
    task automatic t_ftt;
        stuck = 1'b1; util_volt = 8'h40; ch = 0; ha = 0;
        repeat (60 * T) begin cyc(1); ch += xfer_to_emer && !ha[0]; ha = xfer_to_emer; end
        chk(ch, 3);
        chk(common_fault, 1'b1);
        // contacts open after cooldown; generator loss then clears the warning and the run restarts
        ch = 0; hp = 0;
        repeat (1250 * T) begin cyc(1); ch += !engine_start; hp += (ch == 0); end
        chk(hp > 1100 * T, 1'b1);
        chk(ch, 3);
    endtask
    task automatic t_aux;
        aux_bad = 1'b1; cyc(10); chk(common_fault, 1'b1);
        chk(leds.gen_pos ^ leds.util_pos, 1'b1);
        chk(alarm_horn, 1'b1);
        aux_bad = 1'b0; press(1'b1); cyc(6); chk(alarm_horn, 1'b0);
        ch = 0; repeat (30 * T) begin cyc(1); ch += exercise_clear; end
        press(1'b0); chk(ch, 1);
        cyc(8 * T); chk(common_fault, 1'b0);
    endtask
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            do_reset; run_mode = 4'h8 >> i; gen_exercise_req = 1'b1; cyc(60 * T); scan(40 * T);
            chk(ha, (i < 2) ? 20 * T : 8 * T);
            chk(hp, (i % 2) ? 0 : ((i < 2) ? 20 * T : 8 * T));
            chk(gen_exercise_allow, i < 2);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin #2_000_000; n_errors++; finish_test; end
    initial begin
        do_reset; t_outage; do_reset; t_acquire; do_reset; t_ftt; do_reset; t_aux; t_modes; finish_test;
    end
endmodule
